/* File: dds_pkg.sv */
`default_nettype none

package dds_pkg;

    // ----------------------------------------------------------------
    // serial word
    // ----------------------------------------------------------------
    localparam int WORD_BITS = 16;
    localparam int DATA_BITS = 10;
    localparam logic [3:0] BIT_CNT_FIRST = 4'h0;
    localparam logic [3:0] BIT_CNT_LAST = 4'hF;

    // word layout, most significant field first on the wire
    typedef struct packed {
        logic [1:0] sel;
        logic [1:0] mode;
        logic [1:0] pd;
        logic [9:0] data;
    } dds_word_t;

    typedef struct packed {
        logic [9:0] a;
        logic [9:0] b;
    } dds_pair_t;

    typedef struct packed {
        logic active;
        logic [1:0] term;
    } dds_power_t;

    // ----------------------------------------------------------------
    // field encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] SEL_A = 2'h0;
    localparam logic [1:0] SEL_B = 2'h1;
    localparam logic [1:0] MODE_WRITE_ONLY = 2'h0;
    localparam logic [1:0] MODE_WRITE_UPDATE = 2'h1;
    localparam logic [1:0] MODE_UPDATE_BOTH = 2'h2;
    localparam logic [1:0] MODE_BROADCAST = 2'h3;
    localparam logic [1:0] PD_NORMAL = 2'h0;

    localparam dds_pair_t PAIR_RESET = '{a: 10'h000, b: 10'h000};
    localparam dds_power_t POWER_RESET = '{active: 1'b0, term: 2'h0};

    // ----------------------------------------------------------------
    // frame state machine
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_HOLD = 2'b10
    } dds_state_t;

    // ----------------------------------------------------------------
    // pin synchroniser, order {frame_n, sclk, din}
    // ----------------------------------------------------------------
    localparam int PIN_COUNT = 3;
    localparam logic [2:0] PIN_RESET = 3'h6;

    // ----------------------------------------------------------------
    // apb register map
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CHAN_A = 8'h04;
    localparam logic [7:0] ADDR_CHAN_B = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_LAST_WORD = 8'h10;
    localparam logic [7:0] ADDR_COUNTS = 8'h14;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_CLR_BIT = 1;
    localparam logic CTRL_EN_RESET = 1'b1;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [7:0] COUNT_RESET = 8'h00;

endpackage

`default_nettype wire

/* File: dds_sync.sv */
`default_nettype none

module dds_sync
#(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins in, synchronised levels out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ----------------------------------------------------------------
    // two flip-flops per pin
    // ----------------------------------------------------------------
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;

    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        always_ff @(posedge clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                stage1[i] <= RESET_VALUE[i];
                stage2[i] <= RESET_VALUE[i];
            end
            else
            begin
                stage1[i] <= async_in[i];
                stage2[i] <= stage1[i];
            end
        end
    end

    assign sync_out = stage2;

endmodule

`default_nettype wire

/* File: dds_update.sv */
`default_nettype none

module dds_update
(
    // completed word
    input wire logic commit,
    input wire dds_pkg::dds_word_t word,
    // present state
    input wire dds_pkg::dds_pair_t hold,
    input wire dds_pkg::dds_pair_t outs,
    input wire dds_pkg::dds_power_t power,
    // next state
    output dds_pkg::dds_pair_t next_hold,
    output dds_pkg::dds_pair_t next_outs,
    output dds_pkg::dds_power_t next_power
);

    // ----------------------------------------------------------------
    // word decode
    // ----------------------------------------------------------------
    logic hit_a;
    logic hit_b;

    always_comb
    begin
        next_hold = hold;
        next_outs = outs;
        next_power = power;
        hit_a = (word.sel == dds_pkg::SEL_A);
        hit_b = (word.sel == dds_pkg::SEL_B);
        if (commit)
        begin
            if (word.pd != dds_pkg::PD_NORMAL)
            begin
                // power-down word leaves codes untouched
                next_power.active = 1'b1;
                next_power.term = word.pd;
            end
            else
            begin
                next_power.active = 1'b0;
                case (word.mode)
                    dds_pkg::MODE_WRITE_ONLY:
                    begin
                        if (hit_a) next_hold.a = word.data;
                        if (hit_b) next_hold.b = word.data;
                    end
                    dds_pkg::MODE_WRITE_UPDATE:
                    begin
                        if (hit_a)
                        begin
                            next_hold.a = word.data;
                            next_outs.a = word.data;
                        end
                        if (hit_b)
                        begin
                            next_hold.b = word.data;
                            next_outs.b = word.data;
                        end
                    end
                    dds_pkg::MODE_UPDATE_BOTH:
                    begin
                        if (hit_a) next_hold.a = word.data;
                        if (hit_b) next_hold.b = word.data;
                        next_outs.a = hit_a ? word.data : hold.a;
                        next_outs.b = hit_b ? word.data : hold.b;
                    end
                    default:
                    begin
                        next_hold.a = word.data;
                        next_hold.b = word.data;
                        next_outs.a = word.data;
                        next_outs.b = word.data;
                    end
                endcase
            end
        end
    end

endmodule

`default_nettype wire

/* File: dds_top.sv */
`default_nettype none

// How it works
// - after frame falls with the control enable bit set, shift data into 16-bit register on each serial clock fall up to the sixteenth
// - shifting happens only while the frame line stays low
// - outputs update on the sixteenth falling serial edge of an unbroken frame
// - frame rising before the sixteenth edge aborts and discards the partial word
// - reset forces both outputs to zero until a complete valid write
// - each word splits into select, mode, power-down and data fields
// - two-bit mode chooses write-only, addressed-channel update, both channels updated from hold, or broadcast to both channels
// - power-down field enters low power with one of three terminations
// - each channel holds a 10-bit straight binary code
module dds_top
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial pins
    input wire logic frame_n,
    input wire logic sclk,
    input wire logic din,
    // converter outputs
    output logic [9:0] channel_a_output,
    output logic [9:0] channel_b_output,
    output logic power_down,
    output logic [1:0] power_term
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] pin_s;
    logic frame_s;
    logic sclk_s;
    logic din_s;

    dds_sync #(
        .WIDTH(dds_pkg::PIN_COUNT),
        .RESET_VALUE(dds_pkg::PIN_RESET)
    ) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .async_in({frame_n, sclk, din}),
        .sync_out(pin_s)
    );

    assign frame_s = pin_s[2];
    assign sclk_s = pin_s[1];
    assign din_s = pin_s[0];

    // ----------------------------------------------------------------
    // edge detection
    // ----------------------------------------------------------------
    logic frame_d;
    logic sclk_d;
    logic next_frame_d;
    logic next_sclk_d;
    logic sclk_fall;
    logic frame_fall;
    logic frame_rise;

    always_comb
    begin
        next_frame_d = frame_s;
        next_sclk_d = sclk_s;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            frame_d <= 1'b1;
            sclk_d <= 1'b1;
        end
        else
        begin
            frame_d <= next_frame_d;
            sclk_d <= next_sclk_d;
        end
    end

    assign sclk_fall = sclk_d & ~sclk_s;
    assign frame_fall = frame_d & ~frame_s;
    assign frame_rise = ~frame_d & frame_s;

    // ----------------------------------------------------------------
    // frame state machine and shift register
    // ----------------------------------------------------------------
    logic ctrl_en;
    dds_pkg::dds_state_t state;
    dds_pkg::dds_state_t next_state;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [15:0] shreg;
    logic [15:0] next_shreg;
    logic commit;
    logic next_commit;
    logic abort;
    logic next_abort;

    always_comb
    begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_commit = 1'b0;
        next_abort = 1'b0;
        case (state)
            dds_pkg::ST_IDLE:
            begin
                if (ctrl_en && frame_fall)
                begin
                    next_state = dds_pkg::ST_SHIFT;
                    next_bit_cnt = dds_pkg::BIT_CNT_FIRST;
                end
            end
            dds_pkg::ST_SHIFT:
            begin
                if (frame_rise)
                begin
                    next_state = dds_pkg::ST_IDLE;
                    next_abort = 1'b1;
                end
                else if (sclk_fall && !frame_s)
                begin
                    next_shreg = {shreg[14:0], din_s};
                    next_bit_cnt = bit_cnt + 4'h1;
                    if (bit_cnt == dds_pkg::BIT_CNT_LAST)
                    begin
                        next_commit = 1'b1;
                        next_state = dds_pkg::ST_HOLD;
                    end
                end
            end
            dds_pkg::ST_HOLD:
            begin
                // serial edges ignored until the frame line is high again
                if (frame_s)
                begin
                    next_state = dds_pkg::ST_IDLE;
                end
            end
            default:
            begin
                next_state = dds_pkg::ST_HOLD;
            end
        endcase
    end

    // reset enters hold, which the high synchroniser reset value ends on the first cycle, so a frame line already low still starts a frame
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= dds_pkg::ST_HOLD;
            bit_cnt <= dds_pkg::BIT_CNT_FIRST;
            shreg <= dds_pkg::WORD_RESET;
            commit <= 1'b0;
            abort <= 1'b0;
        end
        else
        begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            commit <= next_commit;
            abort <= next_abort;
        end
    end

    // ----------------------------------------------------------------
    // channel codes and power state
    // ----------------------------------------------------------------
    dds_pkg::dds_pair_t hold;
    dds_pkg::dds_pair_t outs;
    dds_pkg::dds_power_t power;
    dds_pkg::dds_pair_t next_hold;
    dds_pkg::dds_pair_t next_outs;
    dds_pkg::dds_power_t next_power;
    logic [15:0] last_word;
    logic [15:0] next_last_word;

    dds_update u_update (
        .commit(commit),
        .word(dds_pkg::dds_word_t'(shreg)),
        .hold(hold),
        .outs(outs),
        .power(power),
        .next_hold(next_hold),
        .next_outs(next_outs),
        .next_power(next_power)
    );

    always_comb
    begin
        next_last_word = commit ? shreg : last_word;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hold <= dds_pkg::PAIR_RESET;
            outs <= dds_pkg::PAIR_RESET;
            power <= dds_pkg::POWER_RESET;
            last_word <= dds_pkg::WORD_RESET;
        end
        else
        begin
            hold <= next_hold;
            outs <= next_outs;
            power <= next_power;
            last_word <= next_last_word;
        end
    end

    assign channel_a_output = outs.a;
    assign channel_b_output = outs.b;
    assign power_down = power.active;
    assign power_term = power.term;

    // ----------------------------------------------------------------
    // frame and abort counters
    // ----------------------------------------------------------------
    logic clr_counts;
    logic [7:0] frame_count;
    logic [7:0] abort_count;
    logic [7:0] next_frame_count;
    logic [7:0] next_abort_count;

    // a frame ending in the clearing cycle still counts
    always_comb
    begin
        next_frame_count = clr_counts ? dds_pkg::COUNT_RESET : frame_count;
        next_abort_count = clr_counts ? dds_pkg::COUNT_RESET : abort_count;
        if (commit)
        begin
            next_frame_count = next_frame_count + 8'h01;
        end
        if (abort)
        begin
            next_abort_count = next_abort_count + 8'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            frame_count <= dds_pkg::COUNT_RESET;
            abort_count <= dds_pkg::COUNT_RESET;
        end
        else
        begin
            frame_count <= next_frame_count;
            abort_count <= next_abort_count;
        end
    end

    // ----------------------------------------------------------------
    // apb slave, one access cycle with registered read data
    // ----------------------------------------------------------------
    logic next_ctrl_en;
    logic next_pready;
    logic next_pslverr;
    logic [31:0] next_prdata;
    logic apb_setup;
    logic apb_write;

    always_comb
    begin
        apb_setup = psel & ~penable;
        apb_write = psel & penable & pready & pwrite;
        next_pready = apb_setup;
        next_pslverr = 1'b0;
        next_prdata = 32'h0000_0000;
        next_ctrl_en = ctrl_en;
        clr_counts = 1'b0;
        if (apb_write && paddr == dds_pkg::ADDR_CTRL)
        begin
            next_ctrl_en = pwdata[dds_pkg::CTRL_EN_BIT];
            clr_counts = pwdata[dds_pkg::CTRL_CLR_BIT];
        end
        if (apb_setup)
        begin
            case (paddr)
                dds_pkg::ADDR_CTRL:
                    next_prdata = {31'h0, ctrl_en};
                dds_pkg::ADDR_CHAN_A:
                    next_prdata = {22'h0, outs.a};
                dds_pkg::ADDR_CHAN_B:
                    next_prdata = {22'h0, outs.b};
                dds_pkg::ADDR_STATUS:
                    next_prdata = {25'h0, state, power.active, power.term,
                                   ~frame_s, 1'b0};
                dds_pkg::ADDR_LAST_WORD:
                    next_prdata = {16'h0000, last_word};
                dds_pkg::ADDR_COUNTS:
                    next_prdata = {16'h0000, abort_count, frame_count};
                default:
                    next_pslverr = 1'b1;
            endcase
            // writes to read-only words are refused too
            if (pwrite && paddr != dds_pkg::ADDR_CTRL)
            begin
                next_pslverr = 1'b1;
                next_prdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_en <= dds_pkg::CTRL_EN_RESET;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            ctrl_en <= next_ctrl_en;
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end

endmodule

`default_nettype wire

/* File: dds_top_chk.sv */
`default_nettype none

module dds_top_chk
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // serial pins
    input wire logic frame_n,
    input wire logic sclk,
    input wire logic din,
    // outputs
    input wire logic [9:0] channel_a_output,
    input wire logic [9:0] channel_b_output,
    input wire logic power_down,
    input wire logic [1:0] power_term
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ----
    // cycles since the last falling serial clock at the pin
    // ----
    logic sclk_q;
    logic next_sclk_q;
    logic [3:0] since_fall;
    logic [3:0] next_since_fall;
    always_comb
    begin
        next_sclk_q = sclk;
        next_since_fall = (since_fall == 4'hF) ? 4'hF : since_fall + 4'h1;
        if (sclk_q && !sclk)
            next_since_fall = 4'h0;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sclk_q <= 1'h1;
            since_fall <= 4'hF;
        end
        else
        begin
            sclk_q <= next_sclk_q;
            since_fall <= next_since_fall;
        end
    end

    // ----
    // assertions
    // ----
    rst_zero_a: assert property ($rose(presetn) |-> channel_a_output == 10'h000
        && channel_b_output == 10'h000) else $error("outputs not zero after reset");
    a_update_a: assert property ($changed(channel_a_output) |-> since_fall <= 4'h7)
        else $error("channel a changed without a frame");
    b_update_a: assert property ($changed(channel_b_output) |-> since_fall <= 4'h7)
        else $error("channel b changed without a frame");
    pd_update_a: assert property ($changed({power_down, power_term}) |-> since_fall <= 4'h7)
        else $error("power state changed without a frame");
    ready_one_a: assert property (pready |=> !pready) else $error("pready longer than a cycle");
    ready_ans_a: assert property (psel && !penable |=> pready && psel && penable)
        else $error("no answer after setup");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
    bad_addr_a: assert property (pready && (paddr > 8'h14 || (pwrite && paddr != 8'h00))
        |-> pslverr) else $error("bad access not refused");
    chan_read_a: assert property (pready && !pwrite && paddr == 8'h04
        |-> prdata == {22'h0, $past(channel_a_output)}) else $error("channel a read wrong");
    frame_c: cover property ($changed(channel_b_output));
    abort_c: cover property ($rose(frame_n) && since_fall < 4'h8);
    err_c: cover property (pready && pslverr);
endmodule

bind dds_top dds_top_chk u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_n(frame_n), .sclk(sclk), .din(din),
    .channel_a_output(channel_a_output), .channel_b_output(channel_b_output),
    .power_down(power_down), .power_term(power_term));

`default_nettype wire

/* File: dds_host.sv */
`default_nettype none

module dds_host
(
    // serial pins to the device
    output var logic frame_n,
    output var logic sclk,
    output var logic din
);
    timeunit 1ns;
    timeprecision 100ps;
    logic tick = 1'h0;
    initial frame_n = 1'h1;
    initial sclk = 1'h1;
    initial din = 1'h0;
    // link clock half period, phase offset from pclk
    initial
    begin
        #3;
        forever #80 tick = ~tick;
    end

    // ----
    // one frame; fewer than sixteen clocks aborts, more are extra
    // ----
    task automatic send(input logic [15:0] w, input int n);
        @(tick);
        din <= w[15];
        frame_n <= 1'h0;
        for (int i = 0; i < n; i++)
        begin
            @(tick);
            sclk <= 1'h0;
            @(tick);
            sclk <= 1'h1;
            din <= (i < 15) ? w[14 - i] : ~din;
        end
        @(tick);
        frame_n <= 1'h1;
        din <= ~din;
        @(tick);
        @(tick);
    endtask
endmodule

`default_nettype wire

/* File: dds_top_tb.sv */
`default_nettype none

module dds_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic frame_n;
    logic sclk;
    logic din;
    logic [9:0] channel_a_output;
    logic [9:0] channel_b_output;
    logic power_down;
    logic [1:0] power_term;
    logic [32:0] rsp;
    int failures = 0;
    int checked = 0;

    initial
    begin
        forever #10 pclk = ~pclk;
    end

    dds_top DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .frame_n(frame_n), .sclk(sclk), .din(din),
        .channel_a_output(channel_a_output), .channel_b_output(channel_b_output),
        .power_down(power_down), .power_term(power_term));
    dds_host u_host (.frame_n(frame_n), .sclk(sclk), .din(din));

    // ----
    // tasks
    // ----
    task automatic end_sim();
        if (failures == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        checked++;
        if (g !== e)
        begin
            $display("BAD %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask

    // response is {pslverr, prdata}
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [32:0] r);
        int n;
        logic rdy;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        rdy = 1'h0;
        r = 33'h0;
        do
        begin
            // sample before the edge that closes the access
            @(negedge pclk);
            n++;
            rdy = (pready === 1'h1);
            r = {pslverr, prdata};
            @(posedge pclk);
        end
        while (!rdy && n < 20);
        if (!rdy)
        begin
            failures++;
            end_sim();
        end
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic outs(input logic [9:0] a, input logic [9:0] b);
        chk("pins", {13'h0, a, b}, {13'h0, channel_a_output, channel_b_output});
        apb(1'h0, dds_pkg::ADDR_CHAN_A, 32'h0, rsp);
        chk("chan_a", {23'h0, a}, rsp);
        apb(1'h0, dds_pkg::ADDR_CHAN_B, 32'h0, rsp);
        chk("chan_b", {23'h0, b}, rsp);
    endtask

    task automatic frame(input logic [1:0] s, input logic [1:0] m, input logic [1:0] p,
        input logic [9:0] d, input int n);
        u_host.send({s, m, p, d}, n);
    endtask

    // ----
    // sequence
    // ----
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        outs(10'h000, 10'h000);
        apb(1'h0, dds_pkg::ADDR_CTRL, 32'h0, rsp);
        chk("ctrl", 33'h1, rsp);
        apb(1'h0, 8'h18, 32'h0, rsp);
        chk("unmapped", 33'h100000000, rsp);
        apb(1'h1, dds_pkg::ADDR_CHAN_A, 32'h3FF, rsp);
        chk("wr_ro", 33'h100000000, rsp);
        frame(dds_pkg::SEL_A, dds_pkg::MODE_WRITE_UPDATE, dds_pkg::PD_NORMAL, 10'h3A5, 16);
        outs(10'h3A5, 10'h000);
        frame(dds_pkg::SEL_B, dds_pkg::MODE_WRITE_UPDATE, dds_pkg::PD_NORMAL, 10'h155, 15);
        outs(10'h3A5, 10'h000);
        apb(1'h0, dds_pkg::ADDR_COUNTS, 32'h0, rsp);
        chk("counts", 33'h0101, rsp);
        frame(dds_pkg::SEL_B, dds_pkg::MODE_WRITE_ONLY, dds_pkg::PD_NORMAL, 10'h2AA, 16);
        outs(10'h3A5, 10'h000);
        frame(dds_pkg::SEL_A, dds_pkg::MODE_UPDATE_BOTH, dds_pkg::PD_NORMAL, 10'h111, 16);
        outs(10'h111, 10'h2AA);
        frame(dds_pkg::SEL_B, dds_pkg::MODE_BROADCAST, dds_pkg::PD_NORMAL, 10'h0F0, 18);
        outs(10'h0F0, 10'h0F0);
        apb(1'h0, dds_pkg::ADDR_LAST_WORD, 32'h0, rsp);
        chk("last", {17'h0, dds_pkg::SEL_B, dds_pkg::MODE_BROADCAST, 12'h0F0}, rsp);
        for (int p = 1; p < 4; p++)
        begin
            frame(dds_pkg::SEL_A, dds_pkg::MODE_WRITE_UPDATE, p[1:0], 10'h3FF, 16);
            chk("pd", {10'h0, 1'h1, p[1:0], 20'h3C0F0},
                {10'h0, power_down, power_term, channel_a_output, channel_b_output});
            apb(1'h0, dds_pkg::ADDR_STATUS, 32'h0, rsp);
            chk("status", {28'h0, 1'h1, p[1:0], 2'h0}, rsp);
        end
        frame(dds_pkg::SEL_A, dds_pkg::MODE_WRITE_UPDATE, dds_pkg::PD_NORMAL, 10'h3FF, 16);
        outs(10'h3FF, 10'h0F0);
        chk("awake", 33'h0, {32'h0, power_down});
        apb(1'h1, dds_pkg::ADDR_CTRL, 32'h0, rsp);
        frame(dds_pkg::SEL_A, dds_pkg::MODE_WRITE_UPDATE, dds_pkg::PD_NORMAL, 10'h001, 16);
        outs(10'h3FF, 10'h0F0);
        apb(1'h0, dds_pkg::ADDR_COUNTS, 32'h0, rsp);
        chk("counts", 33'h0108, rsp);
        apb(1'h1, dds_pkg::ADDR_CTRL, 32'h3, rsp);
        apb(1'h0, dds_pkg::ADDR_CTRL, 32'h0, rsp);
        chk("ctrl", 33'h1, rsp);
        apb(1'h0, dds_pkg::ADDR_COUNTS, 32'h0, rsp);
        chk("cleared", 33'h0, rsp);
        end_sim();
    end
endmodule

`default_nettype wire
